// *** cpu_gp_bank.sv ***
`timescale 1ns/1ps
`default_nettype none

// eight 32-bit general words with lane writes, one registered read port
// and a registered view of word seven for the stack pointer
module cpu_gp_bank (
	input wire logic clk_sys_in, // system clock
	input wire logic rst_in, // synchronous reset, active high
	input wire logic wr_en_in, // write strobe
	input wire logic [2:0] wr_idx_in, // word written
	input wire logic [3:0] wr_be_in, // byte lanes written
	input wire logic [31:0] wr_data_in, // lane-aligned write data
	input wire logic sp_adj_en_in, // stack pointer adjust strobe
	input wire logic [31:0] sp_adj_in, // signed adjust amount
	input wire logic [2:0] rd_idx_in, // word read
	output logic [31:0] rd_data_out, // read data, one cycle later
	output logic [31:0] sp_out // current stack pointer word
);
	typedef struct packed {
		logic [7:0][31:0] words;
		logic [31:0] rd;
	} bank_state_type;

	bank_state_type s;
	bank_state_type n;

	// lane write wins over a stack adjust in the same cycle
	always_comb begin
		n = s;
		if (wr_en_in) begin
			for (int i = 0; i < 4; i++) begin
				if (wr_be_in[i]) begin
					n.words[wr_idx_in][i*8 +: 8] = wr_data_in[i*8 +: 8];
				end
			end
		end else if (sp_adj_en_in) begin
			n.words[7] = s.words[7] + sp_adj_in;
		end
		n.rd = s.words[rd_idx_in];
	end

	// contents are undefined after reset in the real core; zero here keeps sims clean
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign rd_data_out = s.rd;
	assign sp_out = s.words[7];
endmodule

`default_nettype wire

// *** cpu_register_and_flag_core.sv ***
`timescale 1ns/1ps
`default_nettype none

package cpu_core_pkg;
	localparam logic [7:0] FLAGS_RESET = 8'h80;
	localparam int FLAG_I = 7;
	localparam int FLAG_U = 6;
	localparam int FLAG_H = 5;
	localparam int FLAG_N = 3;
	localparam int FLAG_Z = 2;
	localparam int FLAG_V = 1;
	localparam int FLAG_C = 0;
	localparam int HALF_BYTE = 3;
	localparam int HALF_WORD = 11;
	localparam int HALF_LONG = 27;
	localparam logic [31:0] STACK_CALL_BYTES = 32'h0000_0002;
	localparam logic [31:0] STACK_EXC_BYTES = 32'h0000_0004;
	localparam logic [23:0] INSN_BYTES = 24'h00_0002;
	localparam int ADD_SUB_STATES = 2;
	localparam int MULDIV_SHORT_STATES = 14;
	localparam int MULDIV_LONG_STATES = 22;
	localparam logic [4:0] ADD_SUB_LOAD = 5'(ADD_SUB_STATES - 2);
	localparam logic [4:0] SHORT_LOAD = 5'(MULDIV_SHORT_STATES - 2);
	localparam logic [4:0] LONG_LOAD = 5'(MULDIV_LONG_STATES - 2);
	localparam logic [3:0] COND_EQ = 4'h7;

	typedef enum logic [1:0] {SZ_BYTE = 2'h0, SZ_WORD = 2'h1, SZ_LONG = 2'h2} size_type;

	typedef enum logic [4:0] {
		CMD_NOP = 5'h00, CMD_STEP = 5'h01, CMD_WRITE = 5'h02, CMD_ADD = 5'h03,
		CMD_SUB = 5'h04, CMD_CMP = 5'h05, CMD_NEG = 5'h06, CMD_MUL8 = 5'h07,
		CMD_DIV8 = 5'h08, CMD_MUL16 = 5'h09, CMD_DIV16 = 5'h0a, CMD_LOAD_FLAGS = 5'h0b,
		CMD_STORE_FLAGS = 5'h0c, CMD_AND_FLAGS = 5'h0d, CMD_OR_FLAGS = 5'h0e,
		CMD_XOR_FLAGS = 5'h0f, CMD_BRANCH = 5'h10, CMD_CALL = 5'h11, CMD_RET = 5'h12,
		CMD_SLEEP = 5'h13
	} cmd_type;

	typedef enum logic [3:0] {
		ST_VECTOR = 4'b0001, ST_READY = 4'b0010, ST_BUSY = 4'b0100, ST_SLEEP = 4'b1000
	} state_type;

	typedef struct packed {
		state_type state;
		logic [23:0] fetch;
		logic [7:0] flags;
		logic [4:0] cnt;
		logic [31:0] res;
		logic [2:0] res_idx;
		size_type res_size;
		logic res_part;
		logic res_write;
		logic res_flags;
		logic [7:0] res_flag_val;
		logic irq_s1;
		logic irq_s2;
		logic nmi_s1;
		logic nmi_s2;
		logic nmi_s3;
		logic nmi_pend;
		logic ready;
		logic done;
		logic vec_req;
		logic vec_nmi;
		logic exc_ack;
		logic sleeping;
		logic taken;
	} core_state_type;
endpackage

module cpu_register_and_flag_core (
	input wire logic clk_sys_in, // 250 MHz system clock
	input wire logic rst_in, // synchronous reset, active high
	input wire logic cmd_valid_in, // operation offered
	input wire cpu_core_pkg::cmd_type cmd_in, // operation code
	input wire logic [2:0] dst_idx_in, // destination register
	input wire cpu_core_pkg::size_type size_in, // byte, word or long
	input wire logic part_in, // 1 = upper half or upper byte
	input wire logic [31:0] op_a_in, // operand a, data, target, displacement
	input wire logic [31:0] op_b_in, // operand b
	input wire logic [3:0] cond_in, // branch condition code
	input wire logic [2:0] rd_idx_in, // register read index
	input wire logic vec_valid_in, // vector word present
	input wire logic [15:0] vec_data_in, // vector word
	input wire logic irq_pin_in, // maskable interrupt pin, level
	input wire logic nmi_pin_in, // nonmaskable interrupt pin, rising edge
	output logic cmd_ready_out, // operation may be offered
	output logic done_out, // multi-state operation finished
	output logic [23:0] fetch_addr_out, // next fetch address
	output logic [7:0] flags_out, // condition code flags
	output logic [31:0] rd_data_out, // register read data
	output logic [31:0] stack_pointer_out, // register seven
	output logic vec_req_out, // vector fetch wanted
	output logic vec_nmi_out, // vector is the nonmaskable one
	output logic exc_ack_out, // exception accepted, pulse
	output logic sleeping_out, // in power-down state
	output logic branch_taken_out // last branch taken, pulse
);
	localparam cpu_core_pkg::core_state_type RESET_STATE = '{
		state: cpu_core_pkg::ST_VECTOR, flags: cpu_core_pkg::FLAGS_RESET,
		vec_req: 1'b1, res_size: cpu_core_pkg::SZ_BYTE, default: '0};

	cpu_core_pkg::core_state_type s;
	cpu_core_pkg::core_state_type n;
	logic wr_en;
	logic [2:0] wr_idx;
	logic [3:0] wr_be;
	logic [31:0] wr_data;
	logic sp_adj_en;
	logic [31:0] sp_adj;
	logic pend;
	logic [34:0] ar;
	logic [31:0] am;
	logic [31:0] bm;
	logic [15:0] q8;
	logic [31:0] q16;
	logic acc;

	function automatic int size_msb(input cpu_core_pkg::size_type sz);
		return (sz == cpu_core_pkg::SZ_BYTE) ? 7 : (sz == cpu_core_pkg::SZ_WORD) ? 15 : 31;
	endfunction

	function automatic logic [31:0] size_mask(input cpu_core_pkg::size_type sz);
		return (sz == cpu_core_pkg::SZ_BYTE) ? 32'h0000_00ff :
			(sz == cpu_core_pkg::SZ_WORD) ? 32'h0000_ffff : 32'hffff_ffff;
	endfunction

	// normal mode only: upper address byte forced to zero
	function automatic logic [23:0] addr_norm(input logic [23:0] x);
		return {8'h00, x[15:0]};
	endfunction

	// returns {half, overflow, carry, result}; inputs already masked to size
	function automatic logic [34:0] arith(input logic sub, input logic [31:0] a,
			input logic [31:0] b, input cpu_core_pkg::size_type sz);
		logic [32:0] full;
		logic [31:0] x;
		logic [31:0] r;
		int msb;
		int hb;
		logic v;
		msb = size_msb(sz);
		hb = (sz == cpu_core_pkg::SZ_BYTE) ? cpu_core_pkg::HALF_BYTE :
			(sz == cpu_core_pkg::SZ_WORD) ? cpu_core_pkg::HALF_WORD : cpu_core_pkg::HALF_LONG;
		full = sub ? ({1'b0, a} - {1'b0, b}) : ({1'b0, a} + {1'b0, b});
		r = full[31:0] & size_mask(sz);
		x = a ^ b ^ full[31:0];
		v = sub ? ((a[msb] != b[msb]) && (r[msb] != a[msb])) :
			((a[msb] == b[msb]) && (r[msb] != a[msb]));
		return {x[hb + 1], v, full[msb + 1], r};
	endfunction

	// branch decision from the four arithmetic flags
	function automatic logic cond_true(input logic [3:0] c, input logic [7:0] f);
		logic nv;
		nv = f[cpu_core_pkg::FLAG_N] ^ f[cpu_core_pkg::FLAG_V];
		case (c)
			4'h0: return 1'b1;
			4'h1: return 1'b0;
			4'h2: return !(f[cpu_core_pkg::FLAG_C] | f[cpu_core_pkg::FLAG_Z]);
			4'h3: return f[cpu_core_pkg::FLAG_C] | f[cpu_core_pkg::FLAG_Z];
			4'h4: return !f[cpu_core_pkg::FLAG_C];
			4'h5: return f[cpu_core_pkg::FLAG_C];
			4'h6: return !f[cpu_core_pkg::FLAG_Z];
			4'h7: return f[cpu_core_pkg::FLAG_Z];
			4'h8: return !f[cpu_core_pkg::FLAG_V];
			4'h9: return f[cpu_core_pkg::FLAG_V];
			4'ha: return !f[cpu_core_pkg::FLAG_N];
			4'hb: return f[cpu_core_pkg::FLAG_N];
			4'hc: return !nv;
			4'hd: return nv;
			4'he: return !(f[cpu_core_pkg::FLAG_Z] | nv);
			default: return f[cpu_core_pkg::FLAG_Z] | nv;
		endcase
	endfunction

	// sub-word views: lane enables and alignment of the write data
	function automatic logic [35:0] lanes(input cpu_core_pkg::size_type sz, input logic hi,
			input logic [31:0] d);
		case (sz)
			cpu_core_pkg::SZ_BYTE: return hi ? {4'b0010, 16'h0000, d[7:0], 8'h00} :
				{4'b0001, 24'h00_0000, d[7:0]};
			cpu_core_pkg::SZ_WORD: return hi ? {4'b1100, d[15:0], 16'h0000} :
				{4'b0011, 16'h0000, d[15:0]};
			default: return {4'b1111, d};
		endcase
	endfunction

	// unsigned divides; a zero divisor leaves the dividend in place
	always_comb begin
		q8 = op_a_in[15:0];
		q16 = op_a_in;
		if (op_b_in[7:0] != 8'h00) begin
			q8 = {8'(op_a_in[15:0] % {8'h00, op_b_in[7:0]}),
				8'(op_a_in[15:0] / {8'h00, op_b_in[7:0]})};
		end
		if (op_b_in[15:0] != 16'h0000) begin
			q16 = {16'(op_a_in % {16'h0000, op_b_in[15:0]}),
				16'(op_a_in / {16'h0000, op_b_in[15:0]})};
		end
	end

	// next-state logic for the whole core
	always_comb begin
		n = s;
		wr_en = 1'b0;
		wr_idx = dst_idx_in;
		wr_be = 4'h0;
		wr_data = 32'h0000_0000;
		sp_adj_en = 1'b0;
		sp_adj = 32'h0000_0000;
		am = op_a_in & size_mask(size_in);
		bm = op_b_in & size_mask(size_in);
		ar = 35'h0;
		n.irq_s1 = irq_pin_in;
		n.irq_s2 = s.irq_s1;
		n.nmi_s1 = nmi_pin_in;
		n.nmi_s2 = s.nmi_s1;
		n.nmi_s3 = s.nmi_s2;
		n.done = 1'b0;
		n.exc_ack = 1'b0;
		n.taken = 1'b0;
		pend = s.nmi_pend || (s.irq_s2 && !s.flags[cpu_core_pkg::FLAG_I]);
		case (s.state)
			cpu_core_pkg::ST_VECTOR: begin
				if (vec_valid_in) begin
					n.fetch = addr_norm({8'h00, vec_data_in});
					n.vec_req = 1'b0;
					n.state = cpu_core_pkg::ST_READY;
				end
			end
			cpu_core_pkg::ST_BUSY: begin
				if (s.cnt == 5'h00) begin
					{wr_be, wr_data} = lanes(s.res_size, s.res_part, s.res);
					wr_en = s.res_write;
					wr_idx = s.res_idx;
					if (s.res_flags) begin
						n.flags = s.res_flag_val;
					end
					n.done = 1'b1;
					n.state = cpu_core_pkg::ST_READY;
				end else begin
					n.cnt = s.cnt - 5'h01;
				end
			end
			cpu_core_pkg::ST_READY, cpu_core_pkg::ST_SLEEP: begin
				// an offer already shown ready wins; the irq is taken once the core is back in ready or sleep
				if (pend && !(s.ready && cmd_valid_in)) begin
					n.flags[cpu_core_pkg::FLAG_I] = 1'b1;
					n.vec_nmi = s.nmi_pend;
					n.nmi_pend = 1'b0;
					sp_adj_en = 1'b1;
					sp_adj = 32'h0000_0000 - cpu_core_pkg::STACK_EXC_BYTES;
					n.vec_req = 1'b1;
					n.exc_ack = 1'b1;
					n.state = cpu_core_pkg::ST_VECTOR;
				end else if (s.state == cpu_core_pkg::ST_READY && cmd_valid_in && s.ready) begin
					n.res_idx = dst_idx_in;
					n.res_size = size_in;
					n.res_part = part_in;
					n.res_write = 1'b1;
					n.res_flags = 1'b0;
					case (cmd_in)
						cpu_core_pkg::CMD_STEP: begin
							n.fetch = addr_norm(s.fetch + cpu_core_pkg::INSN_BYTES);
						end
						cpu_core_pkg::CMD_WRITE: begin
							{wr_be, wr_data} = lanes(size_in, part_in, op_a_in);
							wr_en = 1'b1;
						end
						cpu_core_pkg::CMD_ADD, cpu_core_pkg::CMD_SUB,
						cpu_core_pkg::CMD_CMP, cpu_core_pkg::CMD_NEG: begin
							if (cmd_in == cpu_core_pkg::CMD_NEG) begin
								ar = arith(1'b1, 32'h0000_0000, am, size_in);
							end else begin
								ar = arith(cmd_in != cpu_core_pkg::CMD_ADD, am, bm, size_in);
							end
							n.res = ar[31:0];
							n.res_write = (cmd_in != cpu_core_pkg::CMD_CMP);
							n.res_flags = 1'b1;
							n.res_flag_val = {s.flags[7:6], ar[34], s.flags[4],
								ar[size_msb(size_in)], ar[31:0] == 32'h0000_0000, ar[33], ar[32]};
							n.cnt = cpu_core_pkg::ADD_SUB_LOAD;
							n.state = cpu_core_pkg::ST_BUSY;
						end
						cpu_core_pkg::CMD_MUL8, cpu_core_pkg::CMD_DIV8: begin
							n.res = (cmd_in == cpu_core_pkg::CMD_MUL8) ?
								{16'h0000, 16'(op_a_in[7:0] * op_b_in[7:0])} : {16'h0000, q8};
							n.res_size = cpu_core_pkg::SZ_WORD;
							n.res_part = 1'b0;
							n.cnt = cpu_core_pkg::SHORT_LOAD;
							n.state = cpu_core_pkg::ST_BUSY;
						end
						cpu_core_pkg::CMD_MUL16, cpu_core_pkg::CMD_DIV16: begin
							n.res = (cmd_in == cpu_core_pkg::CMD_MUL16) ?
								32'(op_a_in[15:0] * op_b_in[15:0]) : q16;
							n.res_size = cpu_core_pkg::SZ_LONG;
							n.cnt = cpu_core_pkg::LONG_LOAD;
							n.state = cpu_core_pkg::ST_BUSY;
						end
						cpu_core_pkg::CMD_LOAD_FLAGS: n.flags = op_a_in[7:0];
						cpu_core_pkg::CMD_AND_FLAGS: n.flags = s.flags & op_a_in[7:0];
						cpu_core_pkg::CMD_OR_FLAGS: n.flags = s.flags | op_a_in[7:0];
						cpu_core_pkg::CMD_XOR_FLAGS: n.flags = s.flags ^ op_a_in[7:0];
						cpu_core_pkg::CMD_STORE_FLAGS: begin
							// flags land in one byte half
							{wr_be, wr_data} = lanes(cpu_core_pkg::SZ_BYTE, part_in, {24'h0, s.flags});
							wr_en = 1'b1;
						end
						cpu_core_pkg::CMD_BRANCH: begin
							// condition from N Z V C
							n.taken = cond_true(cond_in, s.flags);
							if (n.taken) begin
								n.fetch = addr_norm(s.fetch + {{8{op_a_in[15]}}, op_a_in[15:0]});
							end
						end
						cpu_core_pkg::CMD_CALL: begin
							sp_adj_en = 1'b1;
							sp_adj = 32'h0000_0000 - cpu_core_pkg::STACK_CALL_BYTES;
							n.fetch = addr_norm(op_a_in[23:0]);
						end
						cpu_core_pkg::CMD_RET: begin
							sp_adj_en = 1'b1;
							sp_adj = cpu_core_pkg::STACK_CALL_BYTES;
							n.fetch = addr_norm(op_a_in[23:0]);
						end
						cpu_core_pkg::CMD_SLEEP: n.state = cpu_core_pkg::ST_SLEEP;
						default: n.res_write = 1'b0;
					endcase
				end
			end
			default: begin
				n.state = cpu_core_pkg::ST_VECTOR;
				n.vec_req = 1'b1;
			end
		endcase
		// nmi edge set after the take clear, so a new edge is never lost
		if (s.nmi_s2 && !s.nmi_s3) begin
			n.nmi_pend = 1'b1;
		end
		// ready looks at next flags
		// irq read from the second flop only, so the first never fans out
		n.ready = (n.state == cpu_core_pkg::ST_READY) &&
			!(n.nmi_pend || (s.irq_s2 && !n.flags[cpu_core_pkg::FLAG_I]));
		n.sleeping = (n.state == cpu_core_pkg::ST_SLEEP);
	end

	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			s <= RESET_STATE;
		end else begin
			s <= n;
		end
	end

	cpu_gp_bank bank (
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.wr_en_in(wr_en),
		.wr_idx_in(wr_idx),
		.wr_be_in(wr_be),
		.wr_data_in(wr_data),
		.sp_adj_en_in(sp_adj_en),
		.sp_adj_in(sp_adj),
		.rd_idx_in(rd_idx_in),
		.rd_data_out(rd_data_out),
		.sp_out(stack_pointer_out)
	);

	// fetch address bit zero reads zero
	assign fetch_addr_out = {s.fetch[23:1], 1'b0};
	assign cmd_ready_out = s.ready;
	assign done_out = s.done;
	assign flags_out = s.flags;
	assign vec_req_out = s.vec_req;
	assign vec_nmi_out = s.vec_nmi;
	assign exc_ack_out = s.exc_ack;
	assign sleeping_out = s.sleeping;
	assign branch_taken_out = s.taken;
	assign acc = cmd_valid_in && cmd_ready_out;

	// checks beside the logic
	property p_space;
		@(posedge clk_sys_in) disable iff (rst_in) fetch_addr_out[23:16] == 8'h00;
	endproperty
	a_space: assert property (p_space) else $error("fetch outside 64k");
	property p_even;
		@(posedge clk_sys_in) disable iff (rst_in) fetch_addr_out[0] == 1'b0;
	endproperty
	a_even: assert property (p_even) else $error("odd fetch address");
	property p_addsub;
		@(posedge clk_sys_in) disable iff (rst_in)
			acc && cmd_in == cpu_core_pkg::CMD_ADD |=> !done_out ##1 done_out;
	endproperty
	a_addsub: assert property (p_addsub) else $error("add not two states");
	property p_mul8;
		@(posedge clk_sys_in) disable iff (rst_in)
			acc && cmd_in == cpu_core_pkg::CMD_MUL8 |=> !done_out [*8] ##6 done_out;
	endproperty
	a_mul8: assert property (p_mul8) else $error("short multiply timing");
	property p_div16;
		@(posedge clk_sys_in) disable iff (rst_in)
			acc && cmd_in == cpu_core_pkg::CMD_DIV16 |-> ##21 !done_out ##1 done_out;
	endproperty
	a_div16: assert property (p_div16) else $error("long divide timing");
	property p_rst_mask;
		@(posedge clk_sys_in) disable iff (rst_in) $past(rst_in) |-> flags_out[7] && vec_req_out;
	endproperty
	a_rst_mask: assert property (p_rst_mask) else $error("mask clear after reset");
	property p_exc_mask;
		@(posedge clk_sys_in) disable iff (rst_in) exc_ack_out |-> flags_out[7] && vec_req_out;
	endproperty
	a_exc_mask: assert property (p_exc_mask) else $error("exception left mask clear");
	property p_masked;
		@(posedge clk_sys_in) disable iff (rst_in)
			exc_ack_out && !vec_nmi_out |-> !$past(flags_out[7]);
	endproperty
	a_masked: assert property (p_masked) else $error("masked irq accepted");
	property p_vector;
		@(posedge clk_sys_in) disable iff (rst_in) vec_req_out && vec_valid_in |=>
			!vec_req_out && fetch_addr_out == {8'h00, $past(vec_data_in[15:1]), 1'b0};
	endproperty
	a_vector: assert property (p_vector) else $error("vector not loaded");
	property p_stack;
		@(posedge clk_sys_in) disable iff (rst_in)
			exc_ack_out |-> stack_pointer_out == $past(stack_pointer_out) - 32'h0000_0004;
	endproperty
	a_stack: assert property (p_stack) else $error("stack not adjusted");
	property p_load_flags;
		@(posedge clk_sys_in) disable iff (rst_in) acc && cmd_in == cpu_core_pkg::CMD_LOAD_FLAGS
			|=> flags_out == $past(op_a_in[7:0]) &&
			(flags_out[cpu_core_pkg::FLAG_I] || !$past(s.irq_s2) || !cmd_ready_out);
	endproperty
	a_load_flags: assert property (p_load_flags) else $error("flag load lost");
	property p_branch;
		@(posedge clk_sys_in) disable iff (rst_in)
			acc && cmd_in == cpu_core_pkg::CMD_BRANCH && cond_in == cpu_core_pkg::COND_EQ
			|=> branch_taken_out == $past(flags_out[2]);
	endproperty
	a_branch: assert property (p_branch) else $error("branch ignores zero flag");
	property p_sleep;
		@(posedge clk_sys_in) disable iff (rst_in)
			acc && cmd_in == cpu_core_pkg::CMD_SLEEP |=> sleeping_out || exc_ack_out;
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep not entered");
	c_sleep_wake: cover property (@(posedge clk_sys_in) disable iff (rst_in)
		sleeping_out ##1 exc_ack_out);
	c_nmi: cover property (@(posedge clk_sys_in) disable iff (rst_in) exc_ack_out && vec_nmi_out);
	c_div: cover property (@(posedge clk_sys_in) disable iff (rst_in)
		acc && cmd_in == cpu_core_pkg::CMD_DIV8 ##14 done_out);
endmodule

`default_nettype wire

// *** vec_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// far-side vector memory, answers a request after a chosen number of cycles
module vec_mem_model (
	input wire logic clk_sys_in, // system clock
	input wire logic req_in, // vector fetch wanted
	input wire logic [3:0] delay_in, // answer delay in cycles
	input wire logic [15:0] word_in, // vector word to hand out
	output logic valid_out, // vector word present
	output logic [15:0] data_out // vector word
);
	logic [3:0] cnt;
	initial begin
		valid_out = 1'b0;
		data_out = 16'h5a5a;
		cnt = 4'h0;
	end
	// released bus shows inverted junk so stale data never passes
	// start address supply
	always @(negedge clk_sys_in) begin
		if (!req_in) begin
			valid_out <= 1'b0;
			data_out <= ~data_out;
			cnt <= 4'h0;
		end else if (cnt == delay_in) begin
			valid_out <= 1'b1;
			data_out <= word_in;
		end else begin
			cnt <= cnt + 4'h1;
		end
	end
endmodule
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/1ps
`default_nettype none

module testbench;
	logic clk_sys_in = 0, rst_in = 1, cmd_valid_in = 0, irq_pin_in = 0, nmi_pin_in = 0;
	logic part_in = 0;
	logic [3:0] cond_in = 4'h0;
	cpu_core_pkg::cmd_type cmd_in = cpu_core_pkg::CMD_NOP;
	cpu_core_pkg::size_type size_in = cpu_core_pkg::SZ_LONG;
	logic [2:0] dst_idx_in = 0, rd_idx_in = 0;
	logic [31:0] op_a_in = 0, op_b_in = 0, rd_data_out, stack_pointer_out;
	logic [15:0] vec_data_in, vec_word = 16'h1235;
	logic vec_valid_in, cmd_ready_out, done_out, vec_req_out, vec_nmi_out, exc_ack_out;
	logic sleeping_out, branch_taken_out;
	logic [23:0] fetch_addr_out;
	logic [7:0] flags_out;
	int err_total = 0, n_checks = 0, lat;

	always #2 clk_sys_in = ~clk_sys_in;

	cpu_register_and_flag_core DUT (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
		.cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in), .dst_idx_in(dst_idx_in),
		.size_in(size_in), .part_in(part_in), .op_a_in(op_a_in), .op_b_in(op_b_in),
		.cond_in(cond_in), .rd_idx_in(rd_idx_in), .vec_valid_in(vec_valid_in),
		.vec_data_in(vec_data_in), .irq_pin_in(irq_pin_in), .nmi_pin_in(nmi_pin_in),
		.cmd_ready_out(cmd_ready_out), .done_out(done_out), .fetch_addr_out(fetch_addr_out),
		.flags_out(flags_out), .rd_data_out(rd_data_out), .stack_pointer_out(stack_pointer_out),
		.vec_req_out(vec_req_out), .vec_nmi_out(vec_nmi_out), .exc_ack_out(exc_ack_out),
		.sleeping_out(sleeping_out), .branch_taken_out(branch_taken_out));

	vec_mem_model mem (.clk_sys_in(clk_sys_in), .req_in(vec_req_out), .delay_in(4'h3),
		.word_in(vec_word), .valid_out(vec_valid_in), .data_out(vec_data_in));

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// offer at falling edge, hold until a rising edge with ready high
	task automatic op(input cpu_core_pkg::cmd_type c, input cpu_core_pkg::size_type s,
		input logic [2:0] d, input logic [31:0] a, input logic [31:0] b, input bit wait_done);
		@(negedge clk_sys_in);
		{cmd_valid_in, cmd_in, size_in, dst_idx_in, op_a_in, op_b_in} = {1'b1, c, s, d, a, b};
		for (int i = 0; i < 60 && !cmd_ready_out; i++) @(negedge clk_sys_in);
		@(negedge clk_sys_in);
		cmd_valid_in = 0;
		lat = 1;
		// done pulse counted in states after the taking edge
		while (wait_done && !done_out && lat < 60) begin
			@(negedge clk_sys_in);
			lat++;
		end
	endtask

	task automatic rd(input logic [2:0] idx, input logic [31:0] exp);
		rd_idx_in = idx;
		repeat (2) @(negedge clk_sys_in);
		chk("reg", rd_data_out, exp);
	endtask

	// wait for an exception accept within a bound, then check it against the expected value
	task automatic wait_ack(input int n, input logic exp);
		for (int i = 0; i < n && !exc_ack_out; i++) @(negedge clk_sys_in);
		chk("ack", exc_ack_out, exp);
	endtask

	task automatic t_reset;
		chk("flags", flags_out[7], 1'b1);
		for (int i = 0; i < 40 && !cmd_ready_out; i++) @(negedge clk_sys_in);
		chk("fetch", fetch_addr_out, 24'h001234);
		$display("test reset done");
	endtask

	// one arithmetic case: result lane, flags and two-state completion
	task automatic arith(input cpu_core_pkg::cmd_type c, input cpu_core_pkg::size_type s,
		input logic [31:0] a, input logic [31:0] b, input logic [31:0] exp, input logic [7:0] f);
		op(cpu_core_pkg::CMD_WRITE, cpu_core_pkg::SZ_LONG, 3'h1, 32'h1234_5600 | a, 0, 0);
		op(c, s, 3'h1, a, b, 1);
		chk("latency", lat, 2);
		chk("flags", flags_out, f);
		rd(3'h1, exp);
	endtask

	task automatic t_arith;
		arith(cpu_core_pkg::CMD_ADD, cpu_core_pkg::SZ_BYTE, 32'h0f, 32'h01, 32'h1234_5610, 8'ha0);
		arith(cpu_core_pkg::CMD_ADD, cpu_core_pkg::SZ_BYTE, 32'h7f, 32'h01, 32'h1234_5680, 8'haa);
		arith(cpu_core_pkg::CMD_SUB, cpu_core_pkg::SZ_BYTE, 32'h00, 32'h01, 32'h1234_56ff, 8'ha9);
		arith(cpu_core_pkg::CMD_ADD, cpu_core_pkg::SZ_WORD, 32'hff, 32'hf01, 32'h1234_1000, 8'ha0);
		arith(cpu_core_pkg::CMD_ADD, cpu_core_pkg::SZ_LONG, 32'h0fff_ffff, 32'h1, 32'h1000_0000, 8'ha0);
		arith(cpu_core_pkg::CMD_CMP, cpu_core_pkg::SZ_BYTE, 32'h05, 32'h05, 32'h1234_5605, 8'h84);
		arith(cpu_core_pkg::CMD_NEG, cpu_core_pkg::SZ_BYTE, 32'h01, 32'h00, 32'h1234_56ff, 8'ha9);
		arith(cpu_core_pkg::CMD_ADD, cpu_core_pkg::SZ_BYTE, 32'h00, 32'h00, 32'h1234_5600, 8'h84);
		$display("test arith done");
	endtask

	task automatic t_muldiv;
		op(cpu_core_pkg::CMD_MUL8, cpu_core_pkg::SZ_BYTE, 3'h2, 32'h3, 32'h5, 1);
		chk("mul8", lat, 14);
		rd(3'h2, 32'h0000_000f);
		op(cpu_core_pkg::CMD_DIV8, cpu_core_pkg::SZ_BYTE, 3'h2, 32'h64, 32'h7, 1);
		chk("div8", lat, 14);
		rd(3'h2, 32'h0000_020e);
		op(cpu_core_pkg::CMD_MUL16, cpu_core_pkg::SZ_WORD, 3'h2, 32'h3, 32'h5, 1);
		chk("mul16", lat, 22);
		rd(3'h2, 32'h0000_000f);
		op(cpu_core_pkg::CMD_DIV16, cpu_core_pkg::SZ_WORD, 3'h2, 32'h64, 32'h7, 1);
		chk("div16", lat, 22);
		rd(3'h2, 32'h0002_000e);
		$display("test muldiv done");
	endtask

	// upper views, flag store, branches, step, call and return
	task automatic t_ctrl;
		part_in = 1;
		op(cpu_core_pkg::CMD_WRITE, cpu_core_pkg::SZ_BYTE, 3'h3, 32'hab, 0, 0);
		op(cpu_core_pkg::CMD_WRITE, cpu_core_pkg::SZ_WORD, 3'h3, 32'hcdef, 0, 0);
		part_in = 0;
		op(cpu_core_pkg::CMD_STORE_FLAGS, cpu_core_pkg::SZ_BYTE, 3'h3, 0, 0, 0);
		rd(3'h3, 32'hcdef_ab84);
		cond_in = cpu_core_pkg::COND_EQ;
		op(cpu_core_pkg::CMD_BRANCH, cpu_core_pkg::SZ_BYTE, 0, 32'h10, 0, 0);
		chk("taken", branch_taken_out, 1'b1);
		chk("target", fetch_addr_out, 24'h001244);
		cond_in = 4'h6;
		op(cpu_core_pkg::CMD_BRANCH, cpu_core_pkg::SZ_BYTE, 0, 32'h10, 0, 0);
		chk("not taken", branch_taken_out, 1'b0);
		op(cpu_core_pkg::CMD_STEP, cpu_core_pkg::SZ_BYTE, 0, 0, 0, 0);
		chk("step", fetch_addr_out, 24'h001246);
		op(cpu_core_pkg::CMD_CALL, cpu_core_pkg::SZ_BYTE, 0, 32'h0001_2346, 0, 0);
		chk("call", fetch_addr_out, 24'h002346);
		chk("call sp", stack_pointer_out, 32'hffff_fffe);
		op(cpu_core_pkg::CMD_RET, cpu_core_pkg::SZ_BYTE, 0, 32'h1000, 0, 0);
		chk("ret", fetch_addr_out, 24'h001000);
		chk("ret sp", stack_pointer_out, 32'h0000_0000);
		$display("test ctrl done");
	endtask

	task automatic t_flags_irq;
		irq_pin_in = 1;
		wait_ack(12, 1'b0);
		op(cpu_core_pkg::CMD_LOAD_FLAGS, cpu_core_pkg::SZ_BYTE, 0, 32'h40, 0, 0);
		// cleared mask lets the pending request in
		wait_ack(12, 1'b1);
		irq_pin_in = 0;
		chk("mask", flags_out, 8'hc0);
		chk("sp", stack_pointer_out, 32'hffff_fffc);
		vec_word = 16'h0200;
		nmi_pin_in = 1;
		// let the irq acceptance pulse pass first
		@(negedge clk_sys_in);
		wait_ack(20, 1'b1);
		chk("nmi", vec_nmi_out, 1'b1);
		nmi_pin_in = 0;
		for (int i = 0; i < 40 && !cmd_ready_out; i++) @(negedge clk_sys_in);
		op(cpu_core_pkg::CMD_OR_FLAGS, cpu_core_pkg::SZ_BYTE, 0, 32'h01, 0, 0);
		chk("or", flags_out, 8'hc1);
		op(cpu_core_pkg::CMD_XOR_FLAGS, cpu_core_pkg::SZ_BYTE, 0, 32'h41, 0, 0);
		chk("xor", flags_out, 8'h80);
		op(cpu_core_pkg::CMD_SLEEP, cpu_core_pkg::SZ_BYTE, 0, 0, 0, 0);
		chk("sleep", sleeping_out, 1'b1);
		$display("test flags irq done");
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		repeat (3) @(negedge clk_sys_in);
		rst_in = 0;
		t_reset;
		t_arith;
		t_muldiv;
		t_ctrl;
		t_flags_irq;
		test_done;
	end

	// hang guard well beyond the expected few hundred cycles
	initial begin
		repeat (5000) @(posedge clk_sys_in);
		err_total++;
		test_done;
	end
endmodule
`default_nettype wire
